// ==== core/cs_chan.sv ====
// Functional notes
// - unit selected by 16-bit control word, acknowledged
// - next cycle loads first address into unit's register
// - control cycle selects unit, loads function register
// - each unit owns its own address register
// - channel idles until a steal request arrives
// - grant only highest-priority pending request
// - program clock stops only at cycle end
// - processor registers untouched during steals
// - channel clock runs across consecutive steals by different units
// - each steal moves exactly one word
// - address register drives bus, then increments
// - program resumes when no other unit's request waits
`timescale 1ns/100ps
`default_nettype none
module cs_chan
  import cs_chan_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              nrst,
  // execute-io request
  input  wire xio_req_t          execute_io_instruction,
  input  wire logic [WORD_W-1:0] io_command_word,
  // processor timing
  input  wire logic              cycle_end,
  output logic                   prog_clk_en,
  output logic                   chan_clk_run,
  // io units
  output logic [WORD_W-1:0]      out_bus,
  output logic [UNITS-1:0]       unit_select,
  input  wire logic [UNITS-1:0]  unit_select_ack,
  input  wire logic [UNITS-1:0]  steal_req,
  input  wire logic [UNITS-1:0]  steal_dir_in,
  input  wire logic [WORD_W-1:0] in_bus,
  output logic [UNITS-1:0]       steal_ack,
  output logic [FUNC_W-1:0]      func_out,
  // core storage
  output mem_cmd_t               mem,
  input  wire logic [WORD_W-1:0] mem_rdata
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // lowest index wins; one-hot result
  function automatic logic [UNITS-1:0] pick(input logic [UNITS-1:0] r);
    logic [UNITS-1:0] g;
    g = '0;
    for (int i = UNITS - 1; i >= 0; i--) begin
      if (r[i]) begin
        g = '0;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction : pick

  function automatic logic [UNIT_W-1:0] enc(input logic [UNITS-1:0] oh);
    logic [UNIT_W-1:0] n;
    n = '0;
    for (int i = 0; i < UNITS; i++) begin
      if (oh[i]) begin
        n = UNIT_W'(i);
      end
    end
    return n;
  endfunction : enc

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [ADDR_W-1:0] car_q [UNITS];
  logic [FUNC_W-1:0] func_q [UNITS];
  init_ph_t          ph_q;
  steal_st_t         st_q;
  logic [UNIT_W-1:0] sel_unit_q;
  logic [UNIT_W-1:0] cur_q;
  logic [UNITS-1:0]  select_q;
  logic [UNITS-1:0]  ack_q;
  logic [WORD_W-1:0] out_q;
  logic              prog_en_q;
  logic              chan_run_q;
  mem_cmd_t          mem_q;
  logic              dir_in_q;
  logic [FUNC_W-1:0] func_out_q;

  wire logic [UNITS-1:0]  grant_oh  = pick(steal_req);
  wire logic [UNIT_W-1:0] grant_num = enc(grant_oh);
  wire logic              any_req   = |steal_req;
  wire logic              sel_taken = |(select_q & unit_select_ack);
  wire logic              init_busy = ph_q != ph_idle;
  wire logic              init_go   = ph_q == ph_idle && execute_io_instruction.start && st_q == st_run;
  // an execute-io wins a tie with a steal request, so the first-address
  // load can never meet an address increment in the same cycle
  wire logic              steal_go  = any_req && !init_busy && !init_go;

  // ----------------------------------------
  // initialization sequence
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ph_q       <= ph_idle;
      sel_unit_q <= '0;
      select_q   <= '0;
    end else begin
      case (ph_q)
        ph_idle: begin
          if (init_go) begin
            ph_q       <= ph_ctrl;
            sel_unit_q <= execute_io_instruction.unit;
            select_q   <= UNITS'(1) << execute_io_instruction.unit;
          end
        end
        ph_ctrl: begin
          if (sel_taken) begin
            ph_q     <= ph_data;
            select_q <= '0;
          end
        end
        ph_data: ph_q <= ph_idle;
        default: ph_q <= ph_idle;
      endcase
    end
  end

  // ----------------------------------------
  // per-unit address and function registers
  // ----------------------------------------
  wire logic car_bump = st_q == st_steal;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < UNITS; i++) begin
        car_q[i]  <= CAR_RESET;
        func_q[i] <= FUNC_RESET;
      end
      func_out_q <= FUNC_RESET;
    end else begin
      func_out_q <= func_q[sel_unit_q];
      if (init_go) begin
        func_q[execute_io_instruction.unit] <= execute_io_instruction.func;
      end
      if (ph_q == ph_data) begin
        car_q[sel_unit_q] <= execute_io_instruction.first_addr;
      end else if (car_bump) begin
        car_q[cur_q] <= car_q[cur_q] + CAR_STEP;
      end
    end
  end

  // ----------------------------------------
  // steal sequencer
  // ----------------------------------------
  // a steal only starts between instructions' init phases, so the
  // address register write and the increment never collide
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q       <= st_run;
      cur_q      <= '0;
      ack_q      <= '0;
      prog_en_q  <= 1'b1;
      chan_run_q <= 1'b0;
      mem_q      <= '0;
      dir_in_q   <= 1'b0;
      out_q      <= '0;
    end else begin
      ack_q     <= '0;
      mem_q     <= '0;
      case (st_q)
        st_run: begin
          if (steal_go) begin
            st_q <= st_wait_end;
          end
        end
        st_wait_end: begin
          if (cycle_end) begin
            prog_en_q  <= 1'b0;
            chan_run_q <= 1'b1;
            st_q       <= st_steal;
            cur_q      <= grant_num;
            dir_in_q   <= |(grant_oh & steal_dir_in);
            mem_q.valid <= 1'b1;
            mem_q.write <= |(grant_oh & steal_dir_in);
            mem_q.addr  <= car_q[grant_num];
            mem_q.data  <= in_bus;
          end
        end
        st_steal: begin
          if (!dir_in_q) begin
            out_q <= mem_rdata;
          end
          ack_q[cur_q] <= 1'b1;
          st_q         <= st_done;
        end
        st_done: begin
          // the acked unit's own request is ignored here; only other units keep the channel
          if (any_req & ~ack_q[cur_q] | (|(steal_req & ~(UNITS'(1) << cur_q)))) begin
            st_q <= st_wait_end;
          end else begin
            prog_en_q  <= 1'b1;
            chan_run_q <= 1'b0;
            st_q       <= st_run;
          end
        end
        default: st_q <= st_run;
      endcase
      // the word stands on the bus from the same edge as the select line
      if (init_go || ph_q == ph_ctrl) begin
        out_q <= io_command_word;
      end
    end
  end

  // back-to-back steals skip the cycle-end wait: the program clock
  // is already stopped, so there is no processor cycle to finish
  // (handled by cycle_end being held high by the timing logic)

  assign prog_clk_en  = prog_en_q;
  assign chan_clk_run = chan_run_q;
  assign out_bus      = out_q;
  assign unit_select  = select_q;
  assign steal_ack    = ack_q;
  assign func_out     = func_out_q;
  assign mem          = mem_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_prog_stop_edge: assert property (@(posedge clock) disable iff (!nrst)
    $fell(prog_clk_en) |-> $past(cycle_end)) else $error("program clock stopped mid cycle");
  a_one_word_each: assert property (@(posedge clock) disable iff (!nrst)
    mem.valid |=> !mem.valid && $onehot(steal_ack)) else $error("steal not one word");
  a_car_increment: assert property (@(posedge clock) disable iff (!nrst)
    st_q == st_steal |=> car_q[$past(cur_q)] == $past(car_q[cur_q]) + CAR_STEP)
    else $error("address not incremented");
  a_car_load_data: assert property (@(posedge clock) disable iff (!nrst)
    ph_q == ph_data |=> car_q[$past(sel_unit_q)] == $past(execute_io_instruction.first_addr)) else $error("first address not loaded");
  a_select_ack: assert property (@(posedge clock) disable iff (!nrst)
    ph_q == ph_ctrl && !sel_taken |=> ph_q == ph_ctrl) else $error("advanced without acceptance");
  a_idle_no_req: assert property (@(posedge clock) disable iff (!nrst)
    st_q == st_run && !any_req |=> st_q == st_run) else $error("steal without request");
  a_prio_grant: assert property (@(posedge clock) disable iff (!nrst)
    st_q == st_wait_end && cycle_end |=> ($past(steal_req) & (UNITS'(1) << cur_q)) != '0
      && ($past(steal_req) & ((UNITS'(1) << cur_q) - UNITS'(1))) == '0) else $error("wrong priority");
  a_chan_clk_span: assert property (@(posedge clock) disable iff (!nrst)
    st_q == st_steal |-> chan_clk_run && !prog_clk_en) else $error("clocks wrong during steal");
  a_resume_idle: assert property (@(posedge clock) disable iff (!nrst)
    st_q == st_done && !any_req |=> prog_clk_en) else $error("program not resumed");
  a_regs_held: assert property (@(posedge clock) disable iff (!nrst)
    st_q == st_steal |-> !prog_clk_en) else $error("program ran during steal");
  a_func_load: assert property (@(posedge clock) disable iff (!nrst)
    ph_q == ph_idle && execute_io_instruction.start && st_q == st_run |=> func_q[$past(execute_io_instruction.unit)] == $past(execute_io_instruction.func))
    else $error("function not loaded");
  a_unit_sep: assert property (@(posedge clock) disable iff (!nrst)
    st_q == st_steal && cur_q != 0 |=> car_q[0] == $past(car_q[0])) else $error("foreign register changed");

  c_init: cover property (@(posedge clock) disable iff (!nrst) ph_q == ph_ctrl ##[1:8] ph_q == ph_data);
  c_steal: cover property (@(posedge clock) disable iff (!nrst) st_q == st_steal ##1 st_q == st_done);
  c_b2b: cover property (@(posedge clock) disable iff (!nrst) st_q == st_done ##1 st_q == st_wait_end);

endmodule : cs_chan
`default_nettype wire

// ==== core/cs_chan_pkg.sv ====
package cs_chan_pkg;

  // ----------------------------------------
  // widths and sizes
  // ----------------------------------------
  localparam int WORD_W   = 16;
  localparam int ADDR_W   = 16;
  localparam int FUNC_W   = 8;
  localparam int UNITS    = 4;
  localparam int UNIT_W   = 2;

  // ----------------------------------------
  // reset values and address step
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] CAR_RESET  = 16'h0000;
  localparam logic [FUNC_W-1:0] FUNC_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] CAR_STEP   = 16'h0001;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {ph_idle, ph_ctrl, ph_data} init_ph_t;

  typedef enum logic [1:0] {st_run, st_wait_end, st_steal, st_done} steal_st_t;

  // execute-io request from the processor sequencing
  typedef struct packed {
    logic              start;
    logic [UNIT_W-1:0] unit;
    logic [FUNC_W-1:0] func;
    logic [ADDR_W-1:0] first_addr;
  } xio_req_t;

  // core storage port driven during a steal
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } mem_cmd_t;

endpackage : cs_chan_pkg

// ==== dv/cs_units.sv ====
`timescale 1ns/100ps
`default_nettype none
module cs_units
  import cs_chan_pkg::*;
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // bench control
  input  wire logic [UNITS-1:0] load,
  input  wire logic [7:0]       words,
  // channel side
  input  wire logic [UNITS-1:0] unit_select,
  input  wire logic [UNITS-1:0] steal_ack,
  output logic [UNITS-1:0]      unit_select_ack,
  output logic [UNITS-1:0]      steal_req,
  output logic [WORD_W-1:0]     in_bus
);
  logic [7:0] left_q [UNITS];
  always_comb begin
    for (int u = 0; u < UNITS; u++) steal_req[u] = left_q[u] != 8'h00;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      unit_select_ack <= '0;
      in_bus          <= 16'hffff;
      for (int u = 0; u < UNITS; u++) left_q[u] <= 8'h00;
    end else begin
      unit_select_ack <= unit_select;
      // idle bus toggles so a stale word cannot pass for data
      in_bus <= ~in_bus;
      for (int u = UNITS - 1; u >= 0; u--) begin
        if (load[u]) left_q[u] <= words;
        else if (steal_ack[u]) left_q[u] <= left_q[u] - 8'h01;
        if (left_q[u] != 8'h00 && !steal_ack[u]) in_bus <= 16'h5a00 | 16'(u);
      end
    end
  end
endmodule : cs_units
`default_nettype wire

// ==== dv/cycle_steal_data_channel_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module cycle_steal_data_channel_tb_top
  import cs_chan_pkg::*;
;
  typedef struct {
    logic [UNIT_W-1:0] unit;
    logic [FUNC_W-1:0] func;
    logic [ADDR_W-1:0] addr;
    logic              dir;
    logic [7:0]        n;
    logic [ADDR_W-1:0] last;
  } row_t;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic              clock, nrst, cycle_end, prog_clk_en, chan_clk_run, prev_en, prev_ce;
  xio_req_t          execute_io_instruction;
  mem_cmd_t          mem;
  logic [WORD_W-1:0] cmd, out_bus, in_bus, mem_rdata, last_addr;
  logic [UNITS-1:0]  unit_select, unit_select_ack, steal_req, dir, steal_ack, load;
  logic [FUNC_W-1:0] func_out;
  logic [7:0]        words;
  logic [ADDR_W-1:0] exp_addr [UNITS];
  int                g, last_g, acks, rises, phase, cyc, err_count, samples_checked;
  row_t              rows [3] = '{'{2'h0, 8'h11, 16'h0100, 1'b1, 8'h03, 16'h0102},
                                  '{2'h2, 8'h82, 16'hfffe, 1'b0, 8'h03, 16'h0000},
                                  '{2'h3, 8'hc3, 16'h2000, 1'b1, 8'h01, 16'h2000}};
  cs_chan cs_chan_i (.clock(clock), .nrst(nrst), .execute_io_instruction(execute_io_instruction), .io_command_word(cmd),
    .cycle_end(cycle_end), .prog_clk_en(prog_clk_en), .chan_clk_run(chan_clk_run),
    .out_bus(out_bus), .unit_select(unit_select), .unit_select_ack(unit_select_ack),
    .steal_req(steal_req), .steal_dir_in(dir), .in_bus(in_bus), .steal_ack(steal_ack),
    .func_out(func_out), .mem(mem), .mem_rdata(mem_rdata));
  cs_units cs_units_i (.clock(clock), .nrst(nrst), .load(load), .words(words),
    .unit_select(unit_select), .steal_ack(steal_ack), .unit_select_ack(unit_select_ack),
    .steal_req(steal_req), .in_bus(in_bus));
  // ----------------------------------------
  // processor timing and storage
  // ----------------------------------------
  assign cycle_end = (phase == 3) || !prog_clk_en;
  // storage answers in the cycle that shows the address, where the channel reads it
  assign mem_rdata = ~mem.addr;
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    phase <= (phase + 1) % 4;
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      $display("timeout after %0d cycles", cyc);
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic step();
    @(posedge clock);
    #1;
  endtask : step
  // start pulses for one edge only: a held start would select the unit again
  task automatic init_unit(input row_t r);
    execute_io_instruction.start      = 1'b1;
    execute_io_instruction.unit       = r.unit;
    execute_io_instruction.func       = r.func;
    execute_io_instruction.first_addr = r.addr;
    cmd            = {8'h5c, r.func};
    step();
    execute_io_instruction.start = 1'b0;
    chk("select", 16'(UNITS'(1) << r.unit), 16'(unit_select));
    chk("cmd word", cmd, out_bus);
    repeat (4) step();
    chk("select done", 16'h0000, 16'(unit_select));
    chk("function", 16'(r.func), 16'(func_out));
    exp_addr[r.unit] = r.addr;
  endtask : init_unit
  task automatic run_steals(input logic [UNITS-1:0] which, input logic [7:0] n_each, input int n_total);
    acks  = 0;
    rises = 0;
    load  = which;
    words = n_each;
    step();
    load = '0;
    for (int k = 0; k < 100 && acks < n_total; k++) step();
    repeat (3) step();
    chk("acks", 16'(n_total), 16'(acks));
    chk("run at end", 16'h0001, 16'(prog_clk_en));
    chk("chan at end", 16'h0000, 16'(chan_clk_run));
  endtask : run_steals
  // ----------------------------------------
  // steal monitor
  // ----------------------------------------
  always @(posedge clock) begin
    if (nrst) begin
      if (prev_en && !prog_clk_en) chk("stop edge", 16'h0001, 16'(prev_ce));
      if (prog_clk_en && !prev_en) rises++;
      if (mem.valid) begin
        g = 0;
        for (int i = UNITS - 1; i >= 0; i--) if (steal_req[i]) g = i;
        chk("addr", exp_addr[g], mem.addr);
        chk("write", 16'(dir[g]), 16'(mem.write));
        if (dir[g]) chk("in data", 16'h5a00 | 16'(g), mem.data);
        chk("chan run", 16'h0001, 16'(chan_clk_run && !prog_clk_en));
        exp_addr[g] += 16'h0001;
        last_g    = g;
        last_addr = mem.addr;
      end
      if (steal_ack != 0) begin
        acks++;
        chk("ack", 16'(1 << last_g), 16'(steal_ack));
        if (!dir[last_g]) chk("out data", ~(exp_addr[last_g] - 16'h0001), out_bus);
      end
    end
    prev_en = prog_clk_en;
    prev_ce = cycle_end;
  end
  initial begin
    clock = 1'b0;
    nrst  = 1'b0;
    execute_io_instruction   = '0;
    cmd   = '0;
    load  = '0;
    words = '0;
    dir   = '0;
    for (int u = 0; u < UNITS; u++) exp_addr[u] = CAR_RESET;
    repeat (8) step();
    nrst = 1'b1;
    step();
    chk("run after reset", 16'h0001, 16'(prog_clk_en));
    chk("chan after reset", 16'h0000, 16'(chan_clk_run));
    chk("ack after reset", 16'h0000, 16'(steal_ack));
    $display("test reset done");
    foreach (rows[i]) begin
      dir = UNITS'(rows[i].dir) << rows[i].unit;
      init_unit(rows[i]);
      run_steals(UNITS'(1) << rows[i].unit, rows[i].n, int'(rows[i].n));
      chk("last addr", rows[i].last, last_addr);
      $display("test row %0d done", i);
    end
    // units 1 and 3 ask together: 1 goes first, 3 follows with no program cycle between
    dir = 4'h2;
    init_unit('{2'h1, 8'h41, 16'h0400, 1'b1, 8'h01, 16'h0400});
    run_steals(4'ha, 8'h01, 2);
    chk("resumes once", 16'h0001, 16'(rises));
    chk("last addr", 16'h2001, last_addr);
    $display("test back to back done");
    // reset while unit 0 is in the middle of its words
    dir   = 4'h1;
    load  = 4'h1;
    words = 8'h03;
    step();
    load = '0;
    repeat (4) step();
    nrst = 1'b0;
    #1;
    chk("run in reset", 16'h0001, 16'(prog_clk_en));
    chk("select in reset", 16'h0000, 16'(unit_select));
    chk("func in reset", 16'(FUNC_RESET), 16'(func_out));
    chk("valid in reset", 16'h0000, 16'(mem.valid));
    repeat (2) step();
    nrst = 1'b1;
    for (int u = 0; u < UNITS; u++) exp_addr[u] = CAR_RESET;
    init_unit(rows[0]);
    run_steals(4'h1, rows[0].n, int'(rows[0].n));
    chk("last addr", rows[0].last, last_addr);
    $display("test reset mid steal done");
    give_verdict();
  end
endmodule : cycle_steal_data_channel_tb_top
`default_nettype wire
